// [redriver_mode_select.sv]
// Mode selection and control steering for a four-lane Type-C redriver.
// Assumes two-level pins are asynchronous and are synchronised here; the
// I2C engine, the link state tracker and the analog lanes share i_ref_clk.

`timescale 1ns/1ns

module redriver_mode_select
  import redriver_pkg::*;
#(
  parameter int unsigned HPD_TIMEOUT_CYCLES = HPD_LOW_CYCLES,
  parameter int unsigned STABLE_CYCLES      = STRAP_STABLE_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  input  wire logic [1:0]  i_ctl_sel_lvl,
  input  wire logic [1:0]  i_down_eq_sel_lo,
  input  wire logic [1:0]  i_down_eq_sel_hi,
  input  wire logic [1:0]  i_up_eq_addr_lo,
  input  wire logic [1:0]  i_up_eq_addr_hi,
  input  wire logic        i_flip_scl_pin,
  input  wire logic        i_usb_switch_ctl,
  input  wire logic        i_dp_enable_ctl,
  input  wire logic        i_hot_plug_in,
  input  wire logic        i_swap,
  input  wire logic        i_sleep_n,
  input  wire logic        i_direction_fmt_lo,
  input  wire logic        i_direction_fmt_hi,
  input  wire logic        i_i2c_flip,
  input  wire logic        i_i2c_usb_en,
  input  wire logic        i_i2c_dp_en,
  input  wire logic        i_link_low_power,
  input  wire logic        i_link_disconnected,
  output logic [1:0]       o_mode,
  output logic             o_i2c_en,
  output logic             o_i2c_scl,
  output logic             o_i2c_sda,
  output logic             o_flip,
  output logic             o_usb_en,
  output logic             o_dp_en,
  output logic             o_dp_lanes_en,
  output logic             o_aux_sbu_closed,
  output logic             o_aux_to_sbu2,
  output logic             o_aux_snoop_en,
  output logic [3:0]       o_down_eq,
  output logic [3:0]       o_up_eq,
  output logic [6:0]       o_i2c_addr,
  output logic [1:0]       o_dir_fmt,
  output logic             o_dir_swap,
  output logic             o_rx_detect_en,
  output logic             o_los_lfps_en,
  output logic             o_rx_term_en
);

  // Elaboration stops here when the timeout cannot fit the hot-plug counter.
  if (HPD_TIMEOUT_CYCLES < 2 || HPD_TIMEOUT_CYCLES >= (1 << HPD_CNT_W)) begin : g_bad_timeout
    $error("redriver_mode_select: HPD_TIMEOUT_CYCLES out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap resolution and two-level pin synchronisers.

  strap_codes_t straps;

  strap_resolve #(
    .NUM_STRAPS    (5),
    .STABLE_CYCLES (STABLE_CYCLES)
  ) u_straps (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_level   ({i_ctl_sel_lvl, i_down_eq_sel_lo, i_down_eq_sel_hi,
                 i_up_eq_addr_lo, i_up_eq_addr_hi}),
    .o_code    (straps)
  );

  localparam int unsigned NUM_PINS = 8;

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;

  assign pin_raw = {i_flip_scl_pin, i_usb_switch_ctl, i_dp_enable_ctl, i_hot_plug_in,
                    i_swap, i_sleep_n, i_direction_fmt_hi, i_direction_fmt_lo};

  // Sleep resets to 1 so receiver detection starts enabled, as its default.
  localparam logic [NUM_PINS-1:0] PIN_RESET = 8'h04;

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          pin_meta_reg[p] <= PIN_RESET[p];
          pin_sync_reg[p] <= PIN_RESET[p];
        end else if (i_clk_en) begin
          pin_meta_reg[p] <= pin_raw[p];
          pin_sync_reg[p] <= pin_meta_reg[p];
        end
      end
    end
  endgenerate

  logic flip_scl_s;
  logic usb_sda_s;
  logic dp_ctl_s;
  logic hpd_s;
  logic swap_s;
  logic sleep_n_s;
  logic [1:0] dir_s;

  assign flip_scl_s = pin_sync_reg[7];
  assign usb_sda_s  = pin_sync_reg[6];
  assign dp_ctl_s   = pin_sync_reg[5];
  assign hpd_s      = pin_sync_reg[4];
  assign swap_s     = pin_sync_reg[3];
  assign sleep_n_s  = pin_sync_reg[2];
  assign dir_s      = pin_sync_reg[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  ctl_mode_t mode;
  logic      pin_strap;
  logic      shared_gpio;

  always_comb begin
    unique case (straps.ctl_sel)
      LVL_ZERO:  mode = MODE_PIN_STRAP;
      LVL_RES:   mode = MODE_TEST_I2C;
      LVL_FLOAT: mode = MODE_PIN_NOSNP;
      LVL_ONE:   mode = MODE_I2C;
    endcase
  end

  assign pin_strap   = (mode == MODE_PIN_STRAP) || (mode == MODE_PIN_NOSNP);
  assign shared_gpio = (straps.ctl_sel == LVL_ZERO);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mode         <= MODE_PIN_STRAP;
      o_i2c_en       <= 1'b0;
      o_aux_snoop_en <= 1'b0;
    end else if (i_clk_en) begin
      o_mode         <= mode;
      o_i2c_en       <= !pin_strap;
      o_aux_snoop_en <= (mode != MODE_PIN_NOSNP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared pin steering. The I2C lines idle high with select code 0 and follow the shared pins otherwise.

  logic flip_now;

  assign flip_now = shared_gpio ? flip_scl_s : i_i2c_flip;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_i2c_scl <= 1'b1;
      o_i2c_sda <= 1'b1;
      o_flip    <= 1'b0;
      o_usb_en  <= 1'b0;
    end else if (i_clk_en) begin
      o_i2c_scl <= shared_gpio ? 1'b1 : flip_scl_s;
      o_i2c_sda <= shared_gpio ? 1'b1 : usb_sda_s;
      o_flip    <= flip_now;
      o_usb_en  <= shared_gpio ? usb_sda_s : i_i2c_usb_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hot-plug timeout. Counting only while low means any high sample restarts
  // the full window, so a short glitch never drops the lanes.

  hpd_state_t           hpd_state_reg;
  logic [HPD_CNT_W-1:0] hpd_cnt_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hpd_state_reg <= HPD_PRESENT;
      hpd_cnt_reg   <= '0;
    end else if (i_clk_en) begin
      if (hpd_s || !pin_strap) begin
        hpd_state_reg <= HPD_PRESENT;
        hpd_cnt_reg   <= '0;
      end else begin
        unique case (hpd_state_reg)
          HPD_PRESENT: begin
            hpd_state_reg <= HPD_TIMING;
            hpd_cnt_reg   <= HPD_CNT_W'(1);
          end
          HPD_TIMING: begin
            if (hpd_cnt_reg >= HPD_CNT_W'(HPD_TIMEOUT_CYCLES)) begin
              hpd_state_reg <= HPD_EXPIRED;
            end else begin
              hpd_cnt_reg <= hpd_cnt_reg + HPD_CNT_W'(1);
            end
          end
          HPD_EXPIRED: hpd_state_reg <= HPD_EXPIRED;
          default:     hpd_state_reg <= HPD_PRESENT;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DisplayPort enable and AUX routing.

  logic dp_en_now;

  assign dp_en_now = pin_strap ? dp_ctl_s : i_i2c_dp_en;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dp_en          <= 1'b0;
      o_dp_lanes_en    <= 1'b0;
      o_aux_sbu_closed <= 1'b0;
      o_aux_to_sbu2    <= 1'b0;
    end else if (i_clk_en) begin
      o_dp_en          <= dp_en_now;
      o_dp_lanes_en    <= dp_en_now && (hpd_state_reg != HPD_EXPIRED);
      // The switch stays closed through a hot-plug timeout.
      o_aux_sbu_closed <= dp_en_now;
      o_aux_to_sbu2    <= flip_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Equalizer, address, direction and swap.

  logic [3:0] down_eq_now;
  logic [3:0] up_eq_now;

  assign down_eq_now = {straps.down_eq_sel_hi, straps.down_eq_sel_lo};
  assign up_eq_now   = {straps.up_eq_addr_hi, straps.up_eq_addr_lo};

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_down_eq  <= 4'h0;
      o_up_eq    <= 4'h0;
      o_i2c_addr <= 7'h00;
      o_dir_fmt  <= 2'h0;
      o_dir_swap <= 1'b0;
    end else if (i_clk_en) begin
      o_down_eq  <= swap_s ? up_eq_now : down_eq_now;
      o_up_eq    <= swap_s ? down_eq_now : up_eq_now;
      o_i2c_addr <= shared_gpio ? 7'h00 : {I2C_ADDR_BASE, up_eq_now};
      o_dir_fmt  <= dir_s;
      o_dir_swap <= swap_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver power control.

  rx_power_t rx_now;

  always_comb begin
    rx_now = '{rx_detect_en: 1'b1, los_lfps_en: 1'b1, rx_term_en: 1'b1};
    if (!sleep_n_s) begin
      rx_now.rx_detect_en = 1'b0;
      if (i_link_disconnected) begin
        rx_now.rx_term_en = 1'b0;
      end else if (i_link_low_power) begin
        rx_now.los_lfps_en = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_detect_en <= 1'b1;
      o_los_lfps_en  <= 1'b1;
      o_rx_term_en   <= 1'b1;
    end else if (i_clk_en) begin
      o_rx_detect_en <= rx_now.rx_detect_en;
      o_los_lfps_en  <= rx_now.los_lfps_en;
      o_rx_term_en   <= rx_now.rx_term_en;
    end
  end

endmodule

// [redriver_strap_resolve.sv]
// Package of constants and types for the redriver mode selection logic,
// followed by the four-level strap resolver that the mode logic instantiates.
// Assumes every strap arrives as a two-bit comparator code from the pad ring,
// asynchronous to i_ref_clk.
//
// Behaviour
// - Select code 0 gives pin mode, R test mode with I2C, F pin mode without snoop, 1 I2C mode.
// - With select code 0 the shared clock pin is the orientation flip, else the I2C clock.
// - With select code 0 the shared data pin is the USB switch control, else the I2C data.
// - In pin mode DisplayPort follows its enable pin, high on and low off; else I2C sets it.
// - In pin mode hot-plug low over 2 ms turns off all DisplayPort lanes; AUX-SBU stays closed.
// - The AUX pair is routed to SBU1 or SBU2 by plug orientation and is used for AUX snooping unless select code is F.
// - The two downstream equalizer straps select the downstream receiver gain, up to 11 dB.
// - Upstream straps set upstream gain, up to 9.4 dB, and the I2C address unless select is 0.
// - The two direction-format pins together select the data-path direction format.
// - Swap at 1 exchanges directions and equalizer settings of the two sides; 0 leaves them.
// - Low sleep stops receiver detect, and LOS/LFPS in U2/U3 or termination when disconnected.

`timescale 1ns/1ns

package redriver_pkg;

  localparam logic [1:0] LVL_ZERO  = 2'h0;
  localparam logic [1:0] LVL_RES   = 2'h1;
  localparam logic [1:0] LVL_FLOAT = 2'h2;
  localparam logic [1:0] LVL_ONE   = 2'h3;

  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned HPD_LOW_TIME_NS = 2_000_000;
  // A longest wait rounds down to whole cycles.
  localparam int unsigned HPD_LOW_CYCLES = HPD_LOW_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HPD_CNT_W      = 20;

  localparam int unsigned STRAP_STABLE_CYCLES = 16;

  localparam int unsigned EQ_DOWN_MAX_DB_X10 = 110;
  localparam int unsigned EQ_UP_MAX_DB_X10   = 94;

  localparam logic [2:0] I2C_ADDR_BASE = 3'h2;

  typedef enum logic [1:0] {
    MODE_PIN_STRAP = 2'h0,
    MODE_TEST_I2C  = 2'h1,
    MODE_PIN_NOSNP = 2'h2,
    MODE_I2C       = 2'h3
  } ctl_mode_t;

  typedef enum logic [1:0] {
    HPD_PRESENT = 2'h0,
    HPD_TIMING  = 2'h1,
    HPD_EXPIRED = 2'h3
  } hpd_state_t;

  typedef struct packed {
    logic [1:0] ctl_sel;
    logic [1:0] down_eq_sel_lo;
    logic [1:0] down_eq_sel_hi;
    logic [1:0] up_eq_addr_lo;
    logic [1:0] up_eq_addr_hi;
  } strap_codes_t;

  typedef struct packed {
    logic rx_detect_en;
    logic los_lfps_en;
    logic rx_term_en;
  } rx_power_t;

endpackage

//////////////////////////////////////////////////////////////////////////////

module strap_resolve
  import redriver_pkg::*;
#(
  parameter int unsigned NUM_STRAPS    = 5,
  parameter int unsigned STABLE_CYCLES = STRAP_STABLE_CYCLES
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_clk_en,
  input  wire logic [2*NUM_STRAPS-1:0]   i_level,
  output logic      [2*NUM_STRAPS-1:0]   o_code
);

  // The eight-bit stability counter cannot serve longer windows.
  if (NUM_STRAPS < 1 || STABLE_CYCLES < 2 || STABLE_CYCLES > 255) begin : g_bad_params
    $error("strap_resolve: unsupported parameters");
  end

  // A code must hold for STABLE_CYCLES + 1 samples before it is taken, so a
  // strap passing between thresholds never yields a transient mode.
  genvar g;
  generate
    for (g = 0; g < NUM_STRAPS; g++) begin : g_strap
      logic [1:0] meta_reg;
      logic [1:0] sync_reg;
      logic [1:0] cand_reg;
      logic [7:0] cnt_reg;
      logic [1:0] code_reg;

      always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          meta_reg <= 2'h0;
          sync_reg <= 2'h0;
        end else if (i_clk_en) begin
          meta_reg <= i_level[2*g +: 2];
          sync_reg <= meta_reg;
        end
      end

      always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          cand_reg <= 2'h0;
          cnt_reg  <= 8'h00;
          code_reg <= LVL_ZERO;
        end else if (i_clk_en) begin
          if (sync_reg != cand_reg) begin
            cand_reg <= sync_reg;
            cnt_reg  <= 8'h00;
          end else if (cnt_reg == 8'(STABLE_CYCLES - 1)) begin
            code_reg <= cand_reg;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
      end

      assign o_code[2*g +: 2] = code_reg;
    end
  endgenerate

endmodule

// [strap_host.sv]
// Far-side system controller model: holds the strap and pin levels asked for.
// Assumes requests change only at rising edges, so each level moves one half
// cycle later and is settled by the next rising edge.
`timescale 1ns/1ns
module strap_host
  import redriver_pkg::*;
(
  input  wire strap_codes_t i_strap_req,
  input  wire logic         i_ref_clk,
  input  wire logic [7:0]   i_pin_req,
  output strap_codes_t      o_straps,
  output logic [7:0]        o_pins
);
  initial begin
    o_straps = '0;
    o_pins   = 8'h2C;
  end

  // Falling-edge updates keep every level away from the sampling edge.
  always @(negedge i_ref_clk) begin
    o_straps <= i_strap_req;
    o_pins   <= i_pin_req;
  end
endmodule

// [redriver_mode_select_asserts.sv]
// Port checker for the redriver mode selection block.
// Assumes the clock enable is high around every release of reset.
`timescale 1ns/1ns
module redriver_mode_select_asserts #(
  parameter int unsigned HPD_TIMEOUT_CYCLES = 20
) (
  input wire logic       i_ref_clk,
  input wire logic       i_reset_n,
  input wire logic       i_clk_en,
  input wire logic       i_flip_scl_pin,
  input wire logic       i_hot_plug_in,
  input wire logic       i_sleep_n,
  input wire logic       i_i2c_usb_en,
  input wire logic [1:0] o_mode,
  input wire logic       o_i2c_en,
  input wire logic       o_i2c_scl,
  input wire logic       o_i2c_sda,
  input wire logic       o_flip,
  input wire logic       o_usb_en,
  input wire logic       o_dp_en,
  input wire logic       o_dp_lanes_en,
  input wire logic       o_aux_sbu_closed,
  input wire logic       o_aux_to_sbu2,
  input wire logic       o_aux_snoop_en,
  input wire logic [3:0] o_down_eq,
  input wire logic [3:0] o_up_eq,
  input wire logic [6:0] o_i2c_addr,
  input wire logic       o_dir_swap,
  input wire logic       o_rx_detect_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  logic [31:0] low_cnt;

  // Starts counting two edges before the design when the pin falls, but one edge after it on entering pin mode with the pin already low.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) low_cnt <= '0;
    else if (i_hot_plug_in || o_mode[0]) low_cnt <= '0;
    else if (i_clk_en) low_cnt <= low_cnt + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  i2c_mode_en_a:
  assert property (o_i2c_en == o_mode[0]) else $error("i2c enable disagrees with mode");
  snoop_off_a:
  assert property ((o_mode == 2'h2)[*3] |-> !o_aux_snoop_en) else $error("snoop on in mode F");
  flip_pin_a:
  assert property ((o_mode == 2'h0 && i_clk_en && $stable(i_flip_scl_pin))[*4]
    |-> o_flip == i_flip_scl_pin) else $error("flip does not follow its pin");
  usb_i2c_a:
  assert property ((o_mode != 2'h0 && i_clk_en && $stable(i_i2c_usb_en))[*2]
    |-> o_usb_en == i_i2c_usb_en) else $error("usb switch ignores i2c control");
  shared_idle_a:
  assert property ((o_mode == 2'h0)[*2] |-> o_i2c_scl && o_i2c_sda && o_i2c_addr == 7'h00)
    else $error("i2c side active in pin mode");
  eq_swap_a:
  assert property ((o_mode != 2'h0 && $stable(o_i2c_addr) && $stable(o_dir_swap))[*3]
    |-> (o_dir_swap ? o_down_eq : o_up_eq) == o_i2c_addr[3:0]) else $error("eq swap wrong");
  aux_route_a:
  assert property ($stable(o_flip)[*2] |-> o_aux_to_sbu2 == o_flip) else $error("aux route");
  hpd_expire_a:
  assert property (low_cnt >= HPD_TIMEOUT_CYCLES + 6 && o_dp_en
    |-> !o_dp_lanes_en && o_aux_sbu_closed) else $error("hot plug timeout not applied");
  rx_detect_a:
  assert property ((i_clk_en && $stable(i_sleep_n))[*4] |-> o_rx_detect_en == i_sleep_n)
    else $error("rx detect does not follow sleep");

  cover property (o_mode == 2'h2 && !o_aux_snoop_en);
  cover property (o_dp_en && !o_dp_lanes_en && o_aux_sbu_closed);
  cover property (o_dir_swap && o_mode == 2'h3);
endmodule

bind redriver_mode_select redriver_mode_select_asserts #(
  .HPD_TIMEOUT_CYCLES(HPD_TIMEOUT_CYCLES)
) chk (
  .i_ref_clk, .i_reset_n, .i_clk_en, .i_flip_scl_pin, .i_hot_plug_in, .i_sleep_n,
  .i_i2c_usb_en, .o_mode, .o_i2c_en, .o_i2c_scl, .o_i2c_sda, .o_flip, .o_usb_en,
  .o_dp_en, .o_dp_lanes_en, .o_aux_sbu_closed, .o_aux_to_sbu2, .o_aux_snoop_en,
  .o_down_eq, .o_up_eq, .o_i2c_addr, .o_dir_swap, .o_rx_detect_en
);

// [redriver_mode_select_test.sv]
// Self-checking bench for the redriver mode selection block.
// Assumes the host model and checker are compiled first; short counts keep it quick.
`timescale 1ns/1ns
module redriver_mode_select_test;
  import redriver_pkg::*;
  localparam int unsigned TO = 20;
  localparam int unsigned ST = 3;
  logic         i_ref_clk = 1'b0;
  logic         i_reset_n = 1'b0;
  logic         i_clk_en  = 1'b1;
  logic         i_i2c_flip = 1'b0, i_i2c_usb_en = 1'b0, i_i2c_dp_en = 1'b0;
  logic         i_link_low_power = 1'b0, i_link_disconnected = 1'b0;
  strap_codes_t strap_req = '0, straps;
  logic [7:0]   pin_req = 8'h2C, pins;
  logic [1:0]   o_mode, o_dir_fmt;
  logic [3:0]   o_down_eq, o_up_eq;
  logic [6:0]   o_i2c_addr;
  logic         o_i2c_en, o_i2c_scl, o_i2c_sda, o_flip, o_usb_en, o_dp_en, o_dp_lanes_en;
  logic         o_aux_sbu_closed, o_aux_to_sbu2, o_aux_snoop_en, o_dir_swap;
  logic         o_rx_detect_en, o_los_lfps_en, o_rx_term_en;
  int           bad_count = 0, check_count = 0;

  strap_host host (.i_strap_req(strap_req), .i_ref_clk, .i_pin_req(pin_req),
    .o_straps(straps), .o_pins(pins));
  redriver_mode_select #(.HPD_TIMEOUT_CYCLES(TO), .STABLE_CYCLES(ST)) uut (
    .i_ref_clk, .i_reset_n, .i_clk_en,
    .i_ctl_sel_lvl(straps.ctl_sel), .i_down_eq_sel_lo(straps.down_eq_sel_lo),
    .i_down_eq_sel_hi(straps.down_eq_sel_hi), .i_up_eq_addr_lo(straps.up_eq_addr_lo),
    .i_up_eq_addr_hi(straps.up_eq_addr_hi), .i_flip_scl_pin(pins[0]),
    .i_usb_switch_ctl(pins[1]), .i_dp_enable_ctl(pins[2]), .i_hot_plug_in(pins[3]),
    .i_swap(pins[4]), .i_sleep_n(pins[5]), .i_direction_fmt_lo(pins[6]),
    .i_direction_fmt_hi(pins[7]), .i_i2c_flip, .i_i2c_usb_en, .i_i2c_dp_en,
    .i_link_low_power, .i_link_disconnected, .o_mode, .o_i2c_en, .o_i2c_scl, .o_i2c_sda,
    .o_flip, .o_usb_en, .o_dp_en, .o_dp_lanes_en, .o_aux_sbu_closed, .o_aux_to_sbu2,
    .o_aux_snoop_en, .o_down_eq, .o_up_eq, .o_i2c_addr, .o_dir_fmt, .o_dir_swap,
    .o_rx_detect_en, .o_los_lfps_en, .o_rx_term_en);

  always #2 i_ref_clk = ~i_ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic settle;
    repeat (ST + 8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask

  task automatic check_model;
    int         m;
    logic       f, u, d, sw;
    logic [3:0] dn, up;
    m  = int'(straps.ctl_sel);
    f  = (m == 0) ? pins[0] : i_i2c_flip;
    u  = (m == 0) ? pins[1] : i_i2c_usb_en;
    d  = (m == 0 || m == 2) ? pins[2] : i_i2c_dp_en;
    dn = {straps.down_eq_sel_hi, straps.down_eq_sel_lo};
    up = {straps.up_eq_addr_hi, straps.up_eq_addr_lo};
    sw = pins[4];
    cmp("mode", m, o_mode);
    cmp("i2c and snoop", {m % 2 == 1, m != 2}, {o_i2c_en, o_aux_snoop_en});
    cmp("i2c pins", (m == 0) ? 2'h3 : {pins[0], pins[1]}, {o_i2c_scl, o_i2c_sda});
    cmp("flip usb route", {f, u, f}, {o_flip, o_usb_en, o_aux_to_sbu2});
    cmp("dp enables", {d, d, d}, {o_dp_en, o_dp_lanes_en, o_aux_sbu_closed});
    cmp("equalizers", sw ? {up, dn} : {dn, up}, {o_down_eq, o_up_eq});
    cmp("address", (m == 0) ? 7'h00 : {I2C_ADDR_BASE, up}, o_i2c_addr);
    cmp("direction", {pins[7], pins[6], sw}, {o_dir_fmt, o_dir_swap});
    cmp("rx detect", pins[5], o_rx_detect_en);
    if (!pins[5] && i_link_disconnected) begin
      cmp("rx term", 0, o_rx_term_en);
    end else if (!pins[5] && i_link_low_power) begin
      cmp("los term", 1, {o_los_lfps_en, o_rx_term_en});
    end else begin
      cmp("rx power", 3, {o_los_lfps_en, o_rx_term_en});
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(46451));
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    settle;
    for (int i = 0; i < 40; i++) begin
      {i_i2c_flip, i_i2c_usb_en, i_i2c_dp_en, i_link_low_power, i_link_disconnected} =
        5'($urandom);
      @(posedge i_ref_clk);
      {strap_req, pin_req} = 18'($urandom);
      strap_req.ctl_sel = i[1:0];
      pin_req[3] = 1'b1;
      settle;
      check_model;
    end
    // A one-cycle strap pulse is shorter than the stability window.
    @(posedge i_ref_clk);
    strap_req.ctl_sel = ~strap_req.ctl_sel;
    @(posedge i_ref_clk);
    strap_req.ctl_sel = ~strap_req.ctl_sel;
    repeat (8) begin
      @(negedge i_ref_clk);
      cmp("mode held", strap_req.ctl_sel, o_mode);
    end
    settle;
    check_model;
    @(posedge i_ref_clk);
    strap_req.ctl_sel = 2'h0;
    pin_req = 8'h2C;
    settle;
    @(posedge i_ref_clk);
    pin_req[3] = 1'b0;
    repeat (TO) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    cmp("lanes before timeout", 1, o_dp_lanes_en);
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    cmp("after timeout", 3'b011, {o_dp_lanes_en, o_dp_en, o_aux_sbu_closed});
    @(posedge i_ref_clk);
    pin_req[3] = 1'b1;
    settle;
    check_model;
    // A low clock enable must hold every output while a pin moves.
    i_clk_en = 1'b0;
    @(posedge i_ref_clk);
    pin_req[0] = !pin_req[0];
    repeat (6) @(negedge i_ref_clk);
    cmp("frozen flip", !pin_req[0], o_flip);
    i_clk_en = 1'b1;
    settle;
    check_model;
    @(negedge i_ref_clk);
    i_reset_n = 1'b0;
    @(negedge i_ref_clk);
    cmp("in reset", 6'h0E, {o_mode, o_i2c_scl, o_i2c_sda, o_rx_term_en, o_dp_en});
    repeat (3) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    settle;
    check_model;
    wrap_up;
  end

  // The sequence needs under a thousand cycles; five thousand means a hang.
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    bad_count++;
    wrap_up;
  end
endmodule
